// file: rtl/rsp_pkg.sv
// constants and types shared by both ends of the serial port
package rsp_pkg;
  localparam logic [6:0] RSP_DEV_ADDR = 7'h68;
  localparam int RSP_CLK_KHZ = 250000;
  localparam int RSP_SCL_MAX_KHZ = 100;
  localparam int RSP_QTR_CYC = (RSP_CLK_KHZ + 4 * RSP_SCL_MAX_KHZ - 1) / (4 * RSP_SCL_MAX_KHZ);
  localparam logic [9:0] RSP_QTR_LAST = 10'(RSP_QTR_CYC - 1);
  localparam int RSP_PTR_W = 8;
  localparam int RSP_FIFO_DEPTH = 8;
  localparam logic [3:0] RSP_BYTE_BITS = 4'h8;
  localparam logic [7:0] RSP_PTR_RESET = 8'h00;
  localparam logic [1:0] RSP_PH_LAST = 2'h3;

  typedef enum logic [5:0] {
    SL_IDLE = 6'h01,
    SL_RX = 6'h02,
    SL_RX_ACK = 6'h04,
    SL_TX = 6'h08,
    SL_TX_ACK = 6'h10,
    SL_IGNORE = 6'h20
  } rsp_sl_state_type;

  typedef enum logic [2:0] {
    BY_ADDR = 3'h1,
    BY_PTR = 3'h2,
    BY_DATA = 3'h4
  } rsp_byte_kind_type;

  typedef enum logic [3:0] {
    MS_IDLE = 4'h1,
    MS_START = 4'h2,
    MS_BIT = 4'h4,
    MS_STOP = 4'h8
  } rsp_ms_state_type;

  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_STOP = 2'h1,
    CMD_WRITE = 2'h2,
    CMD_READ = 2'h3
  } rsp_cmd_type;
endpackage

// file: rtl/rsp_i2c_if.sv
// two-wire bus between the controlling end and the clock device end
`timescale 1ns/1ps
interface rsp_i2c_if;
  logic scl_out;
  logic scl_oe;
  logic sda_m_out;
  logic sda_m_oe;
  logic sda_s_out;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // wired-and with pull-ups
  assign scl = (scl_oe & ~scl_out) ? 1'b0 : 1'b1;
  assign sda = ((sda_m_oe & ~sda_m_out) | (sda_s_oe & ~sda_s_out)) ? 1'b0 : 1'b1;

  modport dev (input scl, input sda, output sda_s_out, output sda_s_oe);
  modport host (input scl, input sda, output scl_out, output scl_oe, output sda_m_out, output sda_m_oe);
endinterface

// file: rtl/rsp_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module rsp_fifo
  import rsp_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
)
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic full;
  logic empty;

  // depth must be a power of two for the wrap bit to work
  assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty = (wr_ptr_reg == rd_ptr_reg);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge clk)
  begin
    if (in_valid && !full)
    begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (in_valid && !full)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (out_ready && !empty)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

// file: rtl/rsp_host.sv
// controlling end: makes the bus clock, start, stop and byte transfers
`timescale 1ns/1ps
module rsp_host
  import rsp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // bus
  rsp_i2c_if.host i2c,
  // command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_kind,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_nack,
  // answer port
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_acked
);
  logic scl_m_reg, scl_s_reg, sda_m_reg, sda_s_reg;
  logic [9:0] qcnt_reg;
  logic tick;
  rsp_ms_state_type state_reg;
  logic [1:0] ph_reg;
  logic [3:0] bidx_reg;
  logic [7:0] tx_reg;
  logic [7:0] rx_reg;
  logic ack_bit_reg;
  logic active_reg;
  logic scl_oe_reg, sda_oe_reg;
  logic hold;

  assign i2c.scl_out = 1'b0;
  assign i2c.sda_m_out = 1'b0;
  assign i2c.scl_oe = scl_oe_reg;
  assign i2c.sda_m_oe = sda_oe_reg;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {scl_m_reg, scl_s_reg, sda_m_reg, sda_s_reg} <= 4'hf;
    end
    else
    begin
      scl_m_reg <= i2c.scl;
      scl_s_reg <= scl_m_reg;
      sda_m_reg <= i2c.sda;
      sda_s_reg <= sda_m_reg;
    end
  end

  // quarter bit period, never faster than the standard-mode limit
  assign tick = (qcnt_reg == RSP_QTR_LAST);
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      qcnt_reg <= '0;
    else
      qcnt_reg <= tick ? 10'h000 : qcnt_reg + 10'h001;
  end

  // a fresh start waits for both lines high
  assign hold = (state_reg == MS_START) && (ph_reg == 2'h0) && !active_reg && !(scl_s_reg && sda_s_reg);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= MS_IDLE;
      ph_reg <= 2'h0;
      bidx_reg <= 4'h0;
      tx_reg <= 8'h00;
      rx_reg <= 8'h00;
      ack_bit_reg <= 1'b1;
      active_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_acked <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (state_reg)
        MS_IDLE:
          if (cmd_valid && cmd_ready)
          begin
            cmd_ready <= 1'b0;
            ph_reg <= 2'h0;
            bidx_reg <= 4'h0;
            tx_reg <= (cmd_kind == CMD_WRITE) ? cmd_data : 8'hff;
            ack_bit_reg <= (cmd_kind == CMD_READ) ? cmd_nack : 1'b1;
            case (cmd_kind)
              CMD_START: state_reg <= MS_START;
              CMD_STOP: state_reg <= MS_STOP;
              default: state_reg <= MS_BIT;
            endcase
          end
        MS_START:
          if (tick && !hold)
          begin
            ph_reg <= ph_reg + 2'h1;
            case (ph_reg)
              2'h0: sda_oe_reg <= 1'b0;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b1;
              default:
              begin
                scl_oe_reg <= 1'b1;
                active_reg <= 1'b1;
                state_reg <= MS_IDLE;
                cmd_ready <= 1'b1;
                rsp_valid <= 1'b1;
              end
            endcase
          end
        MS_STOP:
          if (tick)
          begin
            ph_reg <= ph_reg + 2'h1;
            case (ph_reg)
              2'h0: sda_oe_reg <= 1'b1;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2: sda_oe_reg <= 1'b0;
              default:
              begin
                active_reg <= 1'b0;
                state_reg <= MS_IDLE;
                cmd_ready <= 1'b1;
                rsp_valid <= 1'b1;
              end
            endcase
          end
        MS_BIT:
          if (tick)
          begin
            ph_reg <= ph_reg + 2'h1;
            case (ph_reg)
              // data only moves with the clock low, msb first
              2'h0: sda_oe_reg <= (bidx_reg < RSP_BYTE_BITS) ? ~tx_reg[7] : ~ack_bit_reg;
              2'h1: scl_oe_reg <= 1'b0;
              2'h2:
                if (bidx_reg < RSP_BYTE_BITS)
                  rx_reg <= {rx_reg[6:0], sda_s_reg};
                else
                  rsp_acked <= ~sda_s_reg;
              default:
              begin
                scl_oe_reg <= 1'b1;
                tx_reg <= {tx_reg[6:0], 1'b1};
                bidx_reg <= bidx_reg + 4'h1;
                if (bidx_reg == RSP_BYTE_BITS)
                begin
                  sda_oe_reg <= 1'b0;
                  state_reg <= MS_IDLE;
                  cmd_ready <= 1'b1;
                  rsp_valid <= 1'b1;
                  rsp_data <= rx_reg;
                end
              end
            endcase
          end
        default: state_reg <= MS_IDLE;
      endcase
    end
  end
endmodule

// file: rtl/rsp_device.sv
// clock device end: address match, pointer, byte receive and transmit
`timescale 1ns/1ps
module rsp_device
  import rsp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // bus
  rsp_i2c_if.dev i2c,
  // stored bytes, pointer and data
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  // register read side
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data,
  // status
  output logic selected
);
  logic scl_m_reg, scl_s_reg, scl_p_reg;
  logic sda_m_reg, sda_s_reg, sda_p_reg;
  logic scl_rise, scl_fall, start_cond, stop_cond;
  rsp_sl_state_type state_reg;
  rsp_byte_kind_type kind_reg;
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;
  logic read_reg;
  logic mack_reg;
  logic sda_oe_reg;
  logic [7:0] ptr_reg;
  logic push_reg;
  logic [15:0] push_data_reg;
  logic push_ready;
  logic byte_end;
  logic addr_hit;
  logic wr_take;
  logic tx_end;
  logic [15:0] fifo_out;

  // sda is never driven high, only released
  assign i2c.sda_s_out = 1'b0;
  assign i2c.sda_s_oe = sda_oe_reg;
  assign rd_addr = ptr_reg;
  assign wr_addr = fifo_out[15:8];
  assign wr_data = fifo_out[7:0];

  // two-flop synchronisers, third stage for edges
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {scl_m_reg, scl_s_reg, scl_p_reg} <= 3'h7;
      {sda_m_reg, sda_s_reg, sda_p_reg} <= 3'h7;
    end
    else
    begin
      scl_m_reg <= i2c.scl;
      scl_s_reg <= scl_m_reg;
      scl_p_reg <= scl_s_reg;
      sda_m_reg <= i2c.sda;
      sda_s_reg <= sda_m_reg;
      sda_p_reg <= sda_s_reg;
    end
  end

  assign scl_rise = scl_s_reg & ~scl_p_reg;
  assign scl_fall = ~scl_s_reg & scl_p_reg;
  // sda moving under a high clock is never data
  assign start_cond = scl_s_reg & scl_p_reg & sda_p_reg & ~sda_s_reg;
  assign stop_cond = scl_s_reg & scl_p_reg & ~sda_p_reg & sda_s_reg;

  assign byte_end = (state_reg == SL_RX) && scl_fall && (cnt_reg == RSP_BYTE_BITS);
  assign addr_hit = (shift_reg[7:1] == RSP_DEV_ADDR);
  // full fifo refuses the byte with a nack, no clock stretching
  assign wr_take = byte_end && (kind_reg == BY_DATA) && push_ready;
  assign tx_end = (state_reg == SL_TX) && scl_fall && (cnt_reg == RSP_BYTE_BITS);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= SL_IDLE;
      kind_reg <= BY_ADDR;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      read_reg <= 1'b0;
      mack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end
    else if (stop_cond)
    begin
      state_reg <= SL_IDLE;
      sda_oe_reg <= 1'b0;
    end
    else if (start_cond)
    begin
      // also taken mid-transfer as a repeated start
      state_reg <= SL_RX;
      kind_reg <= BY_ADDR;
      cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        SL_RX:
          if (scl_rise)
          begin
            shift_reg <= {shift_reg[6:0], sda_s_reg};
            cnt_reg <= cnt_reg + 4'h1;
          end
          else if (byte_end)
          begin
            cnt_reg <= 4'h0;
            state_reg <= SL_RX_ACK;
            case (kind_reg)
              BY_ADDR:
                if (addr_hit)
                begin
                  sda_oe_reg <= 1'b1;
                  read_reg <= shift_reg[0];
                end
                else
                  state_reg <= SL_IGNORE;
              BY_PTR: sda_oe_reg <= 1'b1;
              default: sda_oe_reg <= push_ready;
            endcase
          end
        SL_RX_ACK:
          // ack held until the clock falls again
          if (scl_fall)
          begin
            if (kind_reg == BY_ADDR && read_reg)
            begin
              state_reg <= SL_TX;
              shift_reg <= rd_data;
              sda_oe_reg <= ~rd_data[7];
            end
            else
            begin
              state_reg <= SL_RX;
              sda_oe_reg <= 1'b0;
              kind_reg <= (kind_reg == BY_ADDR) ? BY_PTR : BY_DATA;
            end
          end
        SL_TX:
          if (scl_rise)
            cnt_reg <= cnt_reg + 4'h1;
          else if (tx_end)
          begin
            sda_oe_reg <= 1'b0;
            state_reg <= SL_TX_ACK;
          end
          else if (scl_fall)
          begin
            sda_oe_reg <= ~shift_reg[6];
            shift_reg <= {shift_reg[6:0], 1'b0};
          end
        SL_TX_ACK:
          if (scl_rise)
            mack_reg <= ~sda_s_reg;
          else if (scl_fall)
          begin
            if (mack_reg)
            begin
              state_reg <= SL_TX;
              cnt_reg <= 4'h0;
              shift_reg <= rd_data;
              sda_oe_reg <= ~rd_data[7];
            end
            else
            begin
              state_reg <= SL_IGNORE;
              sda_oe_reg <= 1'b0;
            end
          end
        SL_IDLE, SL_IGNORE: sda_oe_reg <= 1'b0;
        default: state_reg <= SL_IDLE;
      endcase
    end
  end

  // pointer survives between transfers so a plain read resumes there
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      ptr_reg <= RSP_PTR_RESET;
    else if (byte_end && kind_reg == BY_PTR && !start_cond && !stop_cond)
      ptr_reg <= shift_reg;
    else if ((wr_take || tx_end) && !start_cond && !stop_cond)
      ptr_reg <= ptr_reg + 8'h01;
  end

  // one push per accepted byte, tagged with its pointer
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      push_reg <= 1'b0;
      push_data_reg <= 16'h0000;
    end
    else
    begin
      push_reg <= wr_take && !start_cond && !stop_cond;
      if (wr_take)
        push_data_reg <= {ptr_reg, shift_reg};
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      selected <= 1'b0;
    else
      selected <= (state_reg != SL_IDLE) && (state_reg != SL_IGNORE) && (kind_reg != BY_ADDR || state_reg != SL_RX);
  end

  rsp_fifo #(
    .WIDTH(16),
    .DEPTH(RSP_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(push_reg),
    .in_ready(push_ready),
    .in_data(push_data_reg),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(fifo_out)
  );
endmodule

// file: dv/rsp_bus_properties.sv
// bus-level checks on the two-wire link joining host and device ends
`timescale 1ns/1ps
module rsp_bus_properties
  import rsp_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // resolved lines
  input wire logic scl,
  input wire logic sda,
  // drivers
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_m_out,
  input wire logic sda_m_oe,
  input wire logic sda_s_out,
  input wire logic sda_s_oe
);
  logic scl_d_reg, sda_d_reg, first_reg, rd_reg, busy_reg, mute_reg;
  logic [3:0] bit_reg;
  logic [7:0] sh_reg;
  logic [11:0] per_reg;
  logic st, sp, rise, ack_rise;

  // lines are clean in simulation, so no glitch filter
  assign st = scl && scl_d_reg && sda_d_reg && !sda;
  assign sp = scl && scl_d_reg && !sda_d_reg && sda;
  assign rise = scl && !scl_d_reg;
  assign ack_rise = rise && bit_reg == 4'h8;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      first_reg <= 1'b0;
      rd_reg <= 1'b0;
      busy_reg <= 1'b0;
      mute_reg <= 1'b0;
      per_reg <= 12'hfff;
    end
    else
    begin
      scl_d_reg <= scl;
      sda_d_reg <= sda;
      // saturates so the first pulse after idle never looks fast
      per_reg <= rise ? 12'h000 : (per_reg == 12'hfff ? per_reg : per_reg + 12'h001);
      if (st || sp)
        bit_reg <= 4'h0;
      else if (rise)
        bit_reg <= ack_rise ? 4'h0 : bit_reg + 4'h1;
      if (rise && !ack_rise)
        sh_reg <= {sh_reg[6:0], sda};
      if (st)
        first_reg <= 1'b1;
      else if (ack_rise)
        first_reg <= 1'b0;
      if (ack_rise && first_reg)
        rd_reg <= sh_reg[0];
      if (st)
        busy_reg <= 1'b1;
      else if (sp)
        busy_reg <= 1'b0;
      if (st || sp)
        mute_reg <= 1'b0;
      else if (ack_rise && (first_reg ? sh_reg[7:1] != RSP_DEV_ADDR : rd_reg && sda))
        mute_reg <= 1'b1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_dev_open_drain: assert property (sda_s_oe |-> !sda_s_out)
    else $error("device drives sda high");
  a_host_open_drain: assert property (!(scl_oe && scl_out) && !(sda_m_oe && sda_m_out))
    else $error("host drives a line high");
  a_dev_high_stable: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
    else $error("device moved sda while scl high");
  a_addr_ack_match: assert property (ack_rise && first_reg |-> sda_s_oe == (sh_reg[7:1] == RSP_DEV_ADDR))
    else $error("address acknowledge wrong");
  a_read_release: assert property (ack_rise && rd_reg && !first_reg |-> !sda_s_oe)
    else $error("device holds sda in host ack slot");
  a_mute_quiet: assert property (mute_reg |-> !sda_s_oe)
    else $error("device drives sda while ignoring");
  a_idle_quiet: assert property (!busy_reg |-> !sda_s_oe)
    else $error("device drives sda on idle bus");
  a_clock_period: assert property (rise |-> per_reg >= 12'(RSP_CLK_KHZ / RSP_SCL_MAX_KHZ - 1))
    else $error("scl period too short");
  a_start_hold: assert property (st |-> scl[*8] ##[1:1000] !scl)
    else $error("start not followed by scl low");
endmodule

// file: dv/test_rtc_serial_slave_port.sv
// self-checking bench: host end talks to device end over the two-wire link
`timescale 1ns/1ps
module test_rtc_serial_slave_port
  import rsp_pkg::*;
;
  logic clk, arst_n, cmd_valid, cmd_ready, cmd_nack, rsp_valid, rsp_acked;
  logic wr_valid, wr_ready, selected;
  logic [1:0] cmd_kind;
  logic [7:0] cmd_data, rsp_data, wr_addr, wr_data, rd_addr, rd_data;
  int err_total, checks;

  rsp_i2c_if i2c();
  rsp_host rsp_host_inst (.clk(clk), .arst_n(arst_n), .i2c(i2c), .cmd_valid, .cmd_ready, .cmd_kind,
    .cmd_data, .cmd_nack, .rsp_valid, .rsp_data, .rsp_acked);
  rsp_device rsp_device_inst (.clk(clk), .arst_n(arst_n), .i2c(i2c), .wr_valid, .wr_ready, .wr_addr,
    .wr_data, .rd_addr, .rd_data, .selected);
  rsp_bus_properties rsp_bus_properties_inst (.clk(clk), .arst_n(arst_n), .scl(i2c.scl), .sda(i2c.sda),
    .scl_out(i2c.scl_out), .scl_oe(i2c.scl_oe), .sda_m_out(i2c.sda_m_out), .sda_m_oe(i2c.sda_m_oe),
    .sda_s_out(i2c.sda_s_out), .sda_s_oe(i2c.sda_s_oe));

  // register stand-in: data tied to address so a wrong pointer shows
  assign rd_data = rd_addr ^ 8'h3c;

  always #2 clk = ~clk;

  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one host command, from a falling edge until its answer pulse
  task automatic cmd(input logic [1:0] k, input logic [7:0] d, input logic n);
    int i;
    i = 0;
    cmd_kind = k;
    cmd_data = d;
    cmd_nack = n;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1 && i < 40000)
    begin
      @(negedge clk);
      i++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && i < 40000)
    begin
      @(negedge clk);
      i++;
    end
    // a command that never finishes is a failure, not a silent skip
    if (i >= 40000)
      err_total++;
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // about 120k cycles expected; a byte alone takes 22500
  initial
  begin
    #(160000 * 4);
    err_total++;
    tally_and_finish;
  end

  initial
  begin
    clk = 1'b0;
    arst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = CMD_START;
    cmd_data = 8'h00;
    cmd_nack = 1'b0;
    wr_ready = 1'b0;
    err_total = 0;
    checks = 0;
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    chk("scl_idle", i2c.scl, 1'b1);
    chk("sda_idle", i2c.sda, 1'b1);
    chk("ptr_reset", rd_addr, RSP_PTR_RESET);
    chk("fifo_idle", wr_valid, 1'b0);
    // write: pointer byte then one data byte, held in the queue
    cmd(CMD_START, 8'h00, 1'b0);
    cmd(CMD_WRITE, {RSP_DEV_ADDR, 1'b0}, 1'b0);
    chk("addr_w_ack", rsp_acked, 1'b1);
    chk("selected", selected, 1'b1);
    cmd(CMD_WRITE, 8'h05, 1'b0);
    chk("ptr_ack", rsp_acked, 1'b1);
    chk("ptr_load", rd_addr, 8'h05);
    cmd(CMD_WRITE, 8'ha5, 1'b0);
    chk("data_ack", rsp_acked, 1'b1);
    chk("wr_valid", wr_valid, 1'b1);
    chk("wr_addr", wr_addr, 8'h05);
    chk("wr_data", wr_data, 8'ha5);
    chk("ptr_step", rd_addr, 8'h06);
    $display("test write done");
    // queue keeps its head until popped
    repeat (4) @(negedge clk);
    chk("fifo_hold_valid", wr_valid, 1'b1);
    chk("fifo_hold_addr", wr_addr, 8'h05);
    chk("fifo_hold_data", wr_data, 8'ha5);
    wr_ready = 1'b1;
    @(negedge clk);
    wr_ready = 1'b0;
    chk("wr_drained", wr_valid, 1'b0);
    $display("test fifo done");
    // repeated start straight into a read from the kept pointer
    cmd(CMD_START, 8'h00, 1'b0);
    cmd(CMD_WRITE, {RSP_DEV_ADDR, 1'b1}, 1'b0);
    chk("addr_r_ack", rsp_acked, 1'b1);
    cmd(CMD_READ, 8'h00, 1'b1);
    chk("rd_byte", rsp_data, 8'h06 ^ 8'h3c);
    chk("rd_nack", rsp_acked, 1'b0);
    chk("ptr_rd_step", rd_addr, 8'h07);
    cmd(CMD_STOP, 8'h00, 1'b0);
    chk("released", i2c.sda, 1'b1);
    chk("deselect", selected, 1'b0);
    $display("test read done");
    tally_and_finish;
  end
endmodule
